//--- design/crs_core_reset.sv
/*
  Core reset-state sequencer: forces the minimal processor control state
  on power-up reset, master clear and watchdog outside sleep.
  Assumes master clear and static strap inputs are asynchronous pins,
  and that the watchdog and sleep signals come from core-clock logic.
*/
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "crs_reset_map.svh"
module crs_core_reset
  import crs_pkg::*;
#(
  parameter int CFG_W = `CRS_CFG_STATIC_W
) (
  input  wire logic             ref_clk_in,         // Core clock, 125 MHz
  input  wire logic             resetn_in,          // Power-up reset, sync, active low
  input  wire logic             master_clear_n_in,  // Master clear pin, active low
  input  wire logic             watchdog_timeout_in,// Watchdog event pulse
  input  wire logic             sleep_in,           // Device in sleep
  input  wire logic             debug_boot_in,      // Debug boot option pin
  input  wire logic [CFG_W-1:0] cfg_static_in,      // Static configuration inputs
  input  wire logic             sw_wr_in,           // Software control write
  input  wire logic             sw_bev_in,          // New boot vector select
  input  wire logic             sw_erl_in,          // New error level
  input  wire logic             sw_exl_in,          // New exception level
  input  wire logic [2:0]       sw_k0_in,           // New kseg0 policy
  input  wire logic             sw_sst_in,          // New single step
  input  wire logic             exc_pend_set_in,    // Exception request
  input  wire logic             exc_pend_clr_in,    // Software clears pending
  input  wire logic             gpr_wr_in,          // GPR write
  input  wire logic [4:0]       gpr_waddr_in,       // GPR write index
  input  wire logic [31:0]      gpr_wdata_in,       // GPR write data
  input  wire logic [4:0]       gpr_raddr_in,       // GPR read index
  input  wire logic             bus_req_in,         // Bus transaction request
  output logic                  core_reset_out,     // Reset exception active
  output logic                  boot_vector_select_out, // Status boot vector
  output logic                  tlb_shutdown_flag_out,  // Status shutdown
  output logic                  soft_reset_flag_out,    // Status soft reset
  output logic                  nmi_flag_out,           // Status NMI
  output logic                  error_level_flag_out,   // Status error level
  output logic                  exc_level_flag_out,     // Status exception level
  output logic                  reduced_power_flag_out, // Status reduced power
  output logic [2:0]            kseg0_cache_policy_out, // Config kseg0 policy
  output logic [2:0]            user_seg_cache_policy_out, // Config user policy
  output logic [2:0]            kseg23_cache_policy_out,   // Config kseg2/3 policy
  output logic [CFG_W-1:0]      cfg_static_out,         // Config static fields
  output logic                  debug_mode_flag_out,    // Debug mode
  output logic                  debug_loadstore_segment_sel_out, // Debug segment
  output logic                  debug_fetch_buserr_pending_out,  // Debug bus error
  output logic                  debug_imprecise_exc_inhibit_out, // Debug inhibit
  output logic                  single_step_enable_out, // Debug single step
  output logic [31:0]           fetch_addr_out,         // First fetch address
  output logic                  exc_taken_out,          // Exception taken pulse
  output logic                  exc_pending_out,        // Exception pending
  output logic [31:0]           gpr_rdata_out,          // GPR read data
  output logic                  bus_busy_out,           // Bus transaction pending
  output logic                  bus_done_out            // Bus transaction done
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0]       master_clear_pin_sync_q;
  logic [1:0]       boot_sync_q;
  logic [CFG_W-1:0] cfg_sync1_q;
  logic [CFG_W-1:0] cfg_sync2_q;

  always_ff @(posedge ref_clk_in) begin
    master_clear_pin_sync_q <= {master_clear_pin_sync_q[0], master_clear_n_in};
    boot_sync_q <= {boot_sync_q[0], debug_boot_in};
    cfg_sync1_q <= cfg_static_in;
    cfg_sync2_q <= cfg_sync1_q;
  end

  // Soft reset and watchdog merge into the same reset path
  logic rst_any;
  assign rst_any = !resetn_in || !master_clear_pin_sync_q[1]
                || (watchdog_timeout_in && !sleep_in);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic             boot_vector_select;
    logic             ts;
    logic             srf;
    logic             nmi;
    logic             error_level_flag;
    logic             exl;
    logic             rp;
    logic [2:0]       k0;
    logic [2:0]       ku;
    logic [2:0]       k23;
    logic [CFG_W-1:0] cfg;
    logic             dm;
    logic             debug_loadstore_segment_sel;
    logic             debug_fetch_buserr_pending;
    logic             debug_imprecise_exc_inhibit;
    logic             single_step_enable;
    logic [31:0]      fetch;
    logic             pend;
    logic             taken;
  } crs_core_s;

  crs_core_s s_q;
  crs_core_s s_d;

  // Only control bits reset; GPR storage is never cleared
  logic [31:0] gpr_q [1:31];

  always_comb begin
    s_d       = s_q;
    s_d.taken = 1'b0;
    // Pending survives reset; set wins over clear
    if (exc_pend_clr_in) begin
      s_d.pend = 1'b0;
    end
    if (exc_pend_set_in) begin
      s_d.pend = 1'b1;
    end
    if (exc_pend_set_in && !s_q.error_level_flag && !s_q.exl) begin
      s_d.taken = 1'b1;
    end
    if (sw_wr_in) begin
      s_d.boot_vector_select = sw_bev_in;
      s_d.error_level_flag = sw_erl_in;
      s_d.exl = sw_exl_in;
      s_d.k0  = sw_k0_in;
      s_d.single_step_enable = sw_sst_in;
    end
    if (rst_any) begin
      s_d.boot_vector_select    = `CRS_BEV_RESET;
      s_d.ts     = `CRS_TS_RESET;
      s_d.srf    = `CRS_SR_RESET;
      s_d.nmi    = `CRS_NMI_RESET;
      s_d.error_level_flag    = `CRS_ERL_RESET;
      s_d.rp     = `CRS_RP_RESET;
      s_d.k0     = `CRS_CCA_UNCACHED;
      s_d.ku     = `CRS_CCA_UNCACHED;
      s_d.k23    = `CRS_CCA_UNCACHED;
      s_d.cfg    = cfg_sync2_q;
      s_d.dm     = boot_sync_q[1];
      s_d.debug_loadstore_segment_sel   = `CRS_DBG_CLR;
      s_d.debug_fetch_buserr_pending = `CRS_DBG_CLR;
      s_d.debug_imprecise_exc_inhibit   = `CRS_DBG_CLR;
      s_d.single_step_enable    = `CRS_DBG_CLR;
      s_d.fetch  = boot_sync_q[1] ? `CRS_DEBUG_VECTOR_VA
                                  : `CRS_BOOT_VECTOR_VA;
      s_d.taken  = 1'b0;
    end
  end

  // Sync reset path carries loaded values, so no async constant issue
  always_ff @(posedge ref_clk_in) begin
    s_q <= s_d;
  end

  always_ff @(posedge ref_clk_in) begin
    if (gpr_wr_in && (gpr_waddr_in != 5'h00)) begin
      gpr_q[gpr_waddr_in] <= gpr_wdata_in;
    end
  end

  assign gpr_rdata_out = (gpr_raddr_in == 5'h00) ? `CRS_GPR_ZERO
                                                 : gpr_q[gpr_raddr_in];

  ////////////////////////////////////////////////////////////////////////////
  // Memory interface
  crs_mem_if_sm u_mem (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .abort_in   (rst_any),
    .req_in     (bus_req_in),
    .busy_out   (bus_busy_out),
    .done_out   (bus_done_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign core_reset_out                  = rst_any;
  assign boot_vector_select_out          = s_q.boot_vector_select;
  assign tlb_shutdown_flag_out           = s_q.ts;
  assign soft_reset_flag_out             = s_q.srf;
  assign nmi_flag_out                    = s_q.nmi;
  assign error_level_flag_out            = s_q.error_level_flag;
  assign exc_level_flag_out              = s_q.exl;
  assign reduced_power_flag_out          = s_q.rp;
  assign kseg0_cache_policy_out          = s_q.k0;
  assign user_seg_cache_policy_out       = s_q.ku;
  assign kseg23_cache_policy_out         = s_q.k23;
  assign cfg_static_out                  = s_q.cfg;
  assign debug_mode_flag_out             = s_q.dm;
  assign debug_loadstore_segment_sel_out = s_q.debug_loadstore_segment_sel;
  assign debug_fetch_buserr_pending_out  = s_q.debug_fetch_buserr_pending;
  assign debug_imprecise_exc_inhibit_out = s_q.debug_imprecise_exc_inhibit;
  assign single_step_enable_out          = s_q.single_step_enable;
  assign fetch_addr_out                  = s_q.fetch;
  assign exc_taken_out                   = s_q.taken;
  assign exc_pending_out                 = s_q.pend;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_status_forced: assert property (@(posedge ref_clk_in)
    rst_any |=> boot_vector_select_out && soft_reset_flag_out && error_level_flag_out
      && !tlb_shutdown_flag_out && !nmi_flag_out && !reduced_power_flag_out)
    else $error("status flags wrong after reset");

  a_cache_uncached: assert property (@(posedge ref_clk_in)
    rst_any |=> kseg0_cache_policy_out == 3'h2 && user_seg_cache_policy_out == 3'h2
      && kseg23_cache_policy_out == 3'h2)
    else $error("cache policy not uncached after reset");

  // Pin synchronisers hold no value in the first power-up edges
  a_cfg_loaded: assert property (@(posedge ref_clk_in)
    rst_any && resetn_in |=> cfg_static_out == $past(cfg_sync2_q))
    else $error("static config not loaded at reset");

  a_debug_cleared: assert property (@(posedge ref_clk_in)
    rst_any && resetn_in |=> !debug_loadstore_segment_sel_out && !debug_fetch_buserr_pending_out
      && !debug_imprecise_exc_inhibit_out && !single_step_enable_out
      && debug_mode_flag_out == $past(boot_sync_q[1]))
    else $error("debug bits wrong after reset");

  a_boot_fetch: assert property (@(posedge ref_clk_in)
    rst_any && !boot_sync_q[1] |=> fetch_addr_out == 32'hBFC00000)
    else $error("boot fetch address wrong");

  a_master_clear_pin_reset: assert property (@(posedge ref_clk_in)
    !master_clear_pin_sync_q[1] |-> core_reset_out)
    else $error("master clear did not reset");

  a_wdt_reset: assert property (@(posedge ref_clk_in)
    watchdog_timeout_in && !sleep_in |=> error_level_flag_out && soft_reset_flag_out)
    else $error("watchdog outside sleep did not reset");

  a_gpr_zero: assert property (@(posedge ref_clk_in)
    gpr_raddr_in == 5'h00 |-> gpr_rdata_out == 32'h0)
    else $error("register zero not zero");

  a_pend_kept: assert property (@(posedge ref_clk_in)
    rst_any && s_q.pend && !exc_pend_clr_in |=> exc_pending_out)
    else $error("pending cleared by reset");

  a_blocked_exc: assert property (@(posedge ref_clk_in)
    error_level_flag_out |=> !exc_taken_out)
    else $error("exception taken while error level set");
endmodule

//--- design/crs_reset_map.svh
/*
  Constants for the core reset-state block: field values, boot vectors.
  Assumes inclusion by bare name from design and test files.
*/
`ifndef CRS_RESET_MAP_SVH
`define CRS_RESET_MAP_SVH

`define CRS_BOOT_VECTOR_VA     32'hBFC00000
`define CRS_BOOT_VECTOR_PA     32'h1FC00000
`define CRS_DEBUG_VECTOR_VA    32'hFF200200
`define CRS_CCA_UNCACHED       3'h2
`define CRS_BEV_RESET          1'h1
`define CRS_TS_RESET           1'h0
`define CRS_SR_RESET           1'h1
`define CRS_NMI_RESET          1'h0
`define CRS_ERL_RESET          1'h1
`define CRS_RP_RESET           1'h0
`define CRS_DBG_CLR            1'h0
`define CRS_CFG_STATIC_W       16
`define CRS_GPR_ZERO           32'h00000000

`endif

//--- design/crs_pkg.sv
/*
  Types for the core reset-state block.
  Assumes the map header defines the constants.
*/
package crs_pkg;
  typedef enum logic [1:0] {
    CRS_SM_IDLE,
    CRS_SM_ADDR,
    CRS_SM_DATA
  } crs_sm_e;
endpackage

//--- design/crs_mem_if_sm.sv
/*
  Static-memory interface sequencer with abort on reset.
  Assumes a single clock; reset and abort come from the reset block.
*/
`timescale 1ns/100ps
`include "crs_reset_map.svh"
module crs_mem_if_sm
  import crs_pkg::*;
(
  input  wire logic ref_clk_in,   // Core clock
  input  wire logic resetn_in,    // Sync reset, active low
  input  wire logic abort_in,     // Reset exception taken
  input  wire logic req_in,       // Bus request
  output logic      busy_out,     // Transaction pending
  output logic      done_out      // Transaction completed
);
  typedef struct packed {
    crs_sm_e st;
    logic    done;
  } crs_msm_s;

  crs_msm_s s_q;
  crs_msm_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      CRS_SM_IDLE: begin
        if (req_in) begin
          s_d.st = CRS_SM_ADDR;
        end
      end
      CRS_SM_ADDR: begin
        s_d.st = CRS_SM_DATA;
      end
      CRS_SM_DATA: begin
        s_d.st   = CRS_SM_IDLE;
        s_d.done = 1'b1;
      end
      default: begin
        s_d.st = CRS_SM_IDLE;
      end
    endcase
    // Abort drops any pending transfer with no completion
    if (abort_in) begin
      s_d.st   = CRS_SM_IDLE;
      s_d.done = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_q.st   <= CRS_SM_IDLE;
      s_q.done <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_out = (s_q.st != CRS_SM_IDLE);
  assign done_out = s_q.done;

  a_abort_idles: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    abort_in |=> !busy_out && !done_out)
    else $error("abort did not idle the memory sequencer");
endmodule

//--- test/crs_rst_src.sv
/*
  Model of the reset sources: drives the active-low master clear pin.
  Assumes the bench asks for a clear with a one-cycle request pulse.
*/
`timescale 1ns/100ps
module crs_rst_src #(
  parameter int HOLD = 4
) (
  input  wire logic ref_clk_in,         // Core clock
  input  wire logic pulse_in,           // Request a master clear
  output logic      master_clear_n_out  // Master clear pin, active low
);
  int cnt_q;

  initial begin
    cnt_q = 0;
    master_clear_n_out = 1'h1;
  end

  // Held past the two-stage synchronizer so the core sees four reset edges
  always @(posedge ref_clk_in) begin
    if (pulse_in) begin
      cnt_q <= HOLD;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
    master_clear_n_out <= !(pulse_in || cnt_q > 1);
  end
endmodule

//--- test/tb_cpu_core_reset_state.sv
/*
  Self-checking bench for the core reset-state block.
  Assumes the reset-source model and the design map header.
*/
`timescale 1ns/100ps
`include "crs_reset_map.svh"
module tb_cpu_core_reset_state;
  logic        ref_clk_in, resetn_in, master_clear_n_in, watchdog_timeout_in, sleep_in;
  logic        debug_boot_in, sw_wr_in, sw_bev_in, sw_erl_in, sw_exl_in, sw_sst_in;
  logic        exc_pend_set_in, exc_pend_clr_in, gpr_wr_in, bus_req_in, master_clear_pin_req, seen;
  logic [2:0]  sw_k0_in, kseg0_cache_policy_out, user_seg_cache_policy_out;
  logic [2:0]  kseg23_cache_policy_out;
  logic [4:0]  gpr_waddr_in, gpr_raddr_in;
  logic [15:0] cfg_static_in, cfg_static_out;
  logic [31:0] gpr_wdata_in, gpr_rdata_out, fetch_addr_out;
  logic        core_reset_out, boot_vector_select_out, tlb_shutdown_flag_out;
  logic        soft_reset_flag_out, nmi_flag_out, error_level_flag_out, exc_level_flag_out;
  logic        reduced_power_flag_out, debug_mode_flag_out, debug_loadstore_segment_sel_out;
  logic        debug_fetch_buserr_pending_out, debug_imprecise_exc_inhibit_out;
  logic        single_step_enable_out, exc_taken_out, exc_pending_out;
  logic        bus_busy_out, bus_done_out;
  int          n_mismatch, cmp_count, seed, i;

  crs_core_reset #(.CFG_W(16)) dut_u (
    .ref_clk_in, .resetn_in, .master_clear_n_in, .watchdog_timeout_in, .sleep_in,
    .debug_boot_in, .cfg_static_in, .sw_wr_in, .sw_bev_in, .sw_erl_in, .sw_exl_in,
    .sw_k0_in, .sw_sst_in, .exc_pend_set_in, .exc_pend_clr_in, .gpr_wr_in, .gpr_waddr_in,
    .gpr_wdata_in, .gpr_raddr_in, .bus_req_in, .core_reset_out, .boot_vector_select_out,
    .tlb_shutdown_flag_out, .soft_reset_flag_out, .nmi_flag_out, .error_level_flag_out,
    .exc_level_flag_out, .reduced_power_flag_out, .kseg0_cache_policy_out,
    .user_seg_cache_policy_out, .kseg23_cache_policy_out, .cfg_static_out,
    .debug_mode_flag_out, .debug_loadstore_segment_sel_out, .debug_fetch_buserr_pending_out,
    .debug_imprecise_exc_inhibit_out, .single_step_enable_out, .fetch_addr_out,
    .exc_taken_out, .exc_pending_out, .gpr_rdata_out, .bus_busy_out, .bus_done_out);
  crs_rst_src #(.HOLD(4)) master_clear_pin_u (
    .ref_clk_in, .pulse_in(master_clear_pin_req), .master_clear_n_out(master_clear_n_in));

  initial begin
    ref_clk_in = 1'h0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_fetch(input logic dbg);
    return dbg ? `CRS_DEBUG_VECTOR_VA : 32'hBFC00000;
  endfunction

  function automatic logic [31:0] exp_gpr(input logic [4:0] a, input logic [31:0] d);
    return (a == 5'h0) ? 32'h0 : d;
  endfunction

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_test(input string name);
    $display("Test %s finished, mismatches so far %0d", name, n_mismatch);
  endtask

  task automatic chk_reset(input logic dbg, input logic [15:0] cfg);
    logic [5:0] st;
    logic [8:0] pol;
    logic [3:0] dg;
    st = {boot_vector_select_out, tlb_shutdown_flag_out, soft_reset_flag_out,
          nmi_flag_out, error_level_flag_out, reduced_power_flag_out};
    pol = {kseg0_cache_policy_out, user_seg_cache_policy_out, kseg23_cache_policy_out};
    dg = {debug_loadstore_segment_sel_out, debug_fetch_buserr_pending_out,
          debug_imprecise_exc_inhibit_out, single_step_enable_out};
    chk_word("status", 32'h2A, 32'(st));
    chk_word("policy", 32'h092, 32'(pol));
    chk_word("debug", 32'h0, 32'(dg));
    chk_word("debug_mode", 32'(dbg), 32'(debug_mode_flag_out));
    chk_word("cfg", 32'(cfg), 32'(cfg_static_out));
    chk_word("fetch", exp_fetch(dbg), fetch_addr_out);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic sw_write(input logic b, e, x, input logic [2:0] k, input logic s);
    @(posedge ref_clk_in);
    {sw_wr_in, sw_bev_in, sw_erl_in, sw_exl_in, sw_k0_in, sw_sst_in} <= {1'h1, b, e, x, k, s};
    @(posedge ref_clk_in);
    sw_wr_in <= 1'h0;
    @(negedge ref_clk_in);
  endtask

  task automatic wdt_pulse(input logic sl);
    @(posedge ref_clk_in);
    {watchdog_timeout_in, sleep_in} <= {1'h1, sl};
    @(posedge ref_clk_in);
    {watchdog_timeout_in, sleep_in} <= 2'h0;
    @(negedge ref_clk_in);
  endtask

  task automatic exc_pulse(input logic set, input logic clr);
    @(posedge ref_clk_in);
    {exc_pend_set_in, exc_pend_clr_in} <= {set, clr};
    @(posedge ref_clk_in);
    {exc_pend_set_in, exc_pend_clr_in} <= 2'h0;
    @(negedge ref_clk_in);
  endtask

  task automatic gpr_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    {gpr_wr_in, gpr_waddr_in, gpr_wdata_in, gpr_raddr_in} <= {1'h1, a, d, a};
    @(posedge ref_clk_in);
    gpr_wr_in <= 1'h0;
    @(negedge ref_clk_in);
    chk_word("gpr", exp_gpr(a, d), gpr_rdata_out);
  endtask

  // Pin goes through a synchronizer, so wait for the core's own reset flag
  task automatic master_clear_pin_reset;
    @(posedge ref_clk_in);
    master_clear_pin_req <= 1'h1;
    @(posedge ref_clk_in);
    master_clear_pin_req <= 1'h0;
    repeat (3) @(negedge ref_clk_in);
    chk_word("core_reset", 32'h1, 32'(core_reset_out));
    for (i = 0; i < 20 && core_reset_out !== 1'h0; i++) @(negedge ref_clk_in);
    if (i == 20) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h9F51;
    n_mismatch = 0;
    cmp_count = 0;
    {resetn_in, master_clear_pin_req, watchdog_timeout_in, sleep_in, debug_boot_in} = 5'h0;
    {sw_wr_in, sw_bev_in, sw_erl_in, sw_exl_in, sw_k0_in, sw_sst_in} = 8'h0;
    {exc_pend_set_in, exc_pend_clr_in, gpr_wr_in, bus_req_in} = 4'h0;
    {gpr_waddr_in, gpr_raddr_in, gpr_wdata_in} = 42'h0;
    cfg_static_in = 16'($random(seed));
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_word("core_reset", 32'h1, 32'(core_reset_out));
    @(posedge ref_clk_in);
    resetn_in <= 1'h1;
    @(negedge ref_clk_in);
    chk_reset(1'h0, cfg_static_in);
    end_test("power_up");
    sw_write(1'h0, 1'h0, 1'h0, 3'h3, 1'h1);
    chk_word("ctl", 32'h07, 32'({boot_vector_select_out, error_level_flag_out,
             exc_level_flag_out, kseg0_cache_policy_out, single_step_enable_out}));
    @(posedge ref_clk_in);
    cfg_static_in <= 16'($random(seed));
    master_clear_pin_reset;
    chk_reset(1'h0, cfg_static_in);
    end_test("master_clear");
    sw_write(1'h0, 1'h0, 1'h0, 3'h3, 1'h1);
    wdt_pulse(1'h1);
    chk_word("bev_in_sleep", 32'h0, 32'(boot_vector_select_out));
    wdt_pulse(1'h0);
    chk_reset(1'h0, cfg_static_in);
    end_test("watchdog");
    @(posedge ref_clk_in);
    bus_req_in <= 1'h1;
    @(posedge ref_clk_in);
    bus_req_in <= 1'h0;
    @(negedge ref_clk_in);
    chk_word("busy", 32'h1, 32'(bus_busy_out));
    @(negedge ref_clk_in);
    chk_word("done_early", 32'h0, 32'(bus_done_out));
    @(negedge ref_clk_in);
    chk_word("done", 32'h1, 32'({bus_busy_out, bus_done_out}));
    @(negedge ref_clk_in);
    chk_word("idle", 32'h0, 32'({bus_busy_out, bus_done_out}));
    @(posedge ref_clk_in);
    bus_req_in <= 1'h1;
    @(posedge ref_clk_in);
    {bus_req_in, watchdog_timeout_in} <= 2'h1;
    @(posedge ref_clk_in);
    watchdog_timeout_in <= 1'h0;
    seen = 1'h0;
    repeat (4) begin
      @(negedge ref_clk_in);
      seen = seen | bus_done_out | bus_busy_out;
    end
    chk_word("abort", 32'h0, 32'(seen));
    end_test("bus");
    for (int k = 0; k < 16; k++) gpr_write(k < 3 ? 5'h0 : 5'($random(seed)), $random(seed));
    end_test("gpr");
    exc_pulse(1'h1, 1'h0);
    chk_word("exc_blocked", 32'h2, 32'({exc_pending_out, exc_taken_out}));
    wdt_pulse(1'h0);
    chk_word("exc_kept", 32'h1, 32'(exc_pending_out));
    sw_write(1'h1, 1'h0, 1'h0, 3'h2, 1'h0);
    exc_pulse(1'h0, 1'h1);
    chk_word("exc_clear", 32'h0, 32'(exc_pending_out));
    exc_pulse(1'h1, 1'h0);
    chk_word("exc_taken", 32'h3, 32'({exc_pending_out, exc_taken_out}));
    end_test("exception");
    @(posedge ref_clk_in);
    debug_boot_in <= 1'h1;
    master_clear_pin_reset;
    chk_reset(1'h1, cfg_static_in);
    end_test("debug_boot");
    report_and_stop;
  end

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    $display("Error run limit expected finish seen hang");
    n_mismatch++;
    report_and_stop;
  end
endmodule
